// ---- srsc_pkg.sv ----
// Purpose: Shared constants and types for the SDRAM refresh and self-refresh controller.
// Assumes: Register offsets are byte addresses of aligned 32-bit words.
// Notes:   The command encoding is internal to the memory port and arbitrary.
`default_nettype none

package srsc_pkg;
	localparam logic [3:0]  CFG_OFFSET     = 4'h0;
	localparam logic [3:0]  RFC_OFFSET     = 4'h4;
	localparam logic [3:0]  STAT_OFFSET    = 4'h8;
	localparam int          SR_BIT_POS     = 31;
	localparam int          SR_LANE        = 3;
	localparam logic [7:0]  CFG_RESET      = 8'h00;
	localparam logic [12:0] RR_RESET       = 13'h0190;
	localparam logic [3:0]  BACKLOG_MAX    = 4'hF;
	localparam logic [3:0]  LVL_RELEASE    = 4'h4;
	localparam logic [3:0]  LVL_NEED       = 4'h8;
	localparam logic [3:0]  LVL_MUST       = 4'hC;
	localparam logic [3:0]  INIT_INTERVALS = 4'h8;
	localparam logic [3:0]  INIT_REFRESHES = 4'h8;

	typedef enum logic [2:0] {
		CMD_NOP     = 3'h0,
		CMD_PRE_ALL = 3'h1,
		CMD_REF     = 3'h2,
		CMD_LMR     = 3'h3,
		CMD_SELF_REFRESH_ENTRY_CMD    = 3'h4
	} srsc_cmd_type;

	typedef enum logic [11:0] {
		ST_INIT_ABORT = 12'h001,
		ST_INIT_NOP   = 12'h002,
		ST_INIT_PRE   = 12'h004,
		ST_INIT_REF   = 12'h008,
		ST_INIT_LMR   = 12'h010,
		ST_IDLE       = 12'h020,
		ST_REF_PRE    = 12'h040,
		ST_REF_CMD    = 12'h080,
		ST_SR_PRE     = 12'h100,
		ST_SR_ENTER   = 12'h200,
		ST_SR_ACTIVE  = 12'h400,
		ST_SR_EXIT    = 12'h800
	} srsc_state_type;
endpackage : srsc_pkg

`default_nettype wire

// ---- srsc_refresh_if.sv ----
// Purpose: Carries the refresh period, refresh completion and backlog between controller and counters.
// Assumes: The controller drives the ctrl side, the counter block the counter side.
// Notes:   All signals are synchronous to mclk.
`default_nettype none

interface srsc_refresh_if;
	logic        rrLoad;
	logic [12:0] rrValue;
	logic        refDone;
	logic [3:0]  backlog;
	logic        expire;

	modport counter (input rrLoad, input rrValue, input refDone, output backlog, output expire);
	modport ctrl    (output rrLoad, output rrValue, output refDone, input backlog, input expire);
endinterface : srsc_refresh_if

`default_nettype wire

// ---- srsc_refresh_counter.sv ----
// Purpose: Refresh interval counter and saturating refresh backlog counter.
// Assumes: refDone is a one-cycle pulse per auto-refresh command issued.
// Notes:   expire is registered, so it follows the zero count by one cycle.
`default_nettype none

module srsc_refresh_counter
	import srsc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset,
	srsc_refresh_if.counter rif
);
	logic [12:0] interval_q;
	logic [12:0] interval_d;
	logic [3:0]  backlog_q;
	logic [3:0]  backlog_d;
	logic        expire_q;
	logic        atZero;
	logic        expireNow;

	assign atZero    = (interval_q == 13'h0000);
	// A fresh period load takes precedence over an expiry in the same cycle.
	assign expireNow = atZero && !rif.rrLoad;

	assign interval_d = (rif.rrLoad || atZero) ? rif.rrValue : interval_q - 13'h0001;

	// Both events together cancel out, and either end holds when it would wrap.
	assign backlog_d = (expireNow && rif.refDone) ? backlog_q :
		(expireNow && backlog_q != BACKLOG_MAX) ? backlog_q + 4'h1 :
		(rif.refDone && backlog_q != 4'h0) ? backlog_q - 4'h1 : backlog_q;

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			interval_q <= RR_RESET;
			backlog_q  <= 4'h0;
			expire_q   <= 1'b0;
		end
		else
		begin
			interval_q <= interval_d;
			backlog_q  <= backlog_d;
			expire_q   <= expireNow;
		end
	end

	assign rif.backlog = backlog_q;
	assign rif.expire  = expire_q;

	property p_period_load;
		@(posedge mclk) disable iff (reset)
		rif.rrLoad |=> interval_q == $past(rif.rrValue);
	endproperty
	a_period_load: assert property (p_period_load) else $error("interval counter did not load the period");

	property p_count_down;
		@(posedge mclk) disable iff (reset)
		(!atZero && !rif.rrLoad) |=> interval_q == $past(interval_q) - 13'h0001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("interval counter did not count down by one");

	property p_expiry;
		@(posedge mclk) disable iff (reset)
		expireNow |=> (interval_q == $past(rif.rrValue)) && rif.expire
			&& (backlog_q == ($past(rif.refDone) ? $past(backlog_q) : ($past(backlog_q) == BACKLOG_MAX ?
			BACKLOG_MAX : $past(backlog_q) + 4'h1)));
	endproperty
	a_expiry: assert property (p_expiry) else $error("expiry did not reload or bump the backlog");

	property p_saturate;
		@(posedge mclk) disable iff (reset)
		(rif.refDone && !expireNow && backlog_q == 4'h0) |=> backlog_q == 4'h0;
	endproperty
	a_saturate: assert property (p_saturate) else $error("backlog wrapped below zero");

	property p_cancel;
		@(posedge mclk) disable iff (reset)
		(expireNow && rif.refDone) |=> $stable(backlog_q);
	endproperty
	a_cancel: assert property (p_cancel) else $error("backlog changed on expiry plus refresh");
endmodule : srsc_refresh_counter

`default_nettype wire

// ---- srsc_ctrl.sv ----
// Purpose: Refresh scheduling, initialization and self-refresh control for an SDR SDRAM port.
// Assumes: Inputs are synchronous to mclk; the access engine reports pending requests and open banks.
// Notes:   Gaps between commands for SDRAM timing belong to the access engine and are not modelled.
`default_nettype none

// Operation
// - Keep a 13-bit interval counter, loaded at reset and on period write, counting down.
// - At zero reload the interval counter and bump the backlog unless saturated.
// - Backlog drops per auto-refresh, rises per expiry, saturating at zero and fifteen.
// - An auto-refresh cycle is a precharge of all banks then a refresh command.
// - Periodic auto-refresh can never be disabled, attached memory or not.
// - Backlog 1 to 3: refresh only with no requests pending and no bank open.
// - Backlog 4 to 7: refresh whenever no requests are pending, banks open or not.
// - Backlog 8 to 11: refresh after the current access unless reads are pending.
// - Backlog 12 to 15: refresh back to back until 4 to 7, then accept requests.
// - The refresh period field resets to 190h.
// - Self-refresh request: finish accesses, drain backlog, then issue self-refresh entry.
// - A top-byte-only configuration write changes the self-refresh bit without initialization.
// - In self-refresh keep register access; tri-state rather than park the data bus.
// - Leave self-refresh when the request bit clears or an access is requested.
// - On leaving self-refresh raise clock enable, then run one auto-refresh cycle.
// - New memory characteristics rerun initialization with the period then in force.
// - Initialization: clock enable high, no-ops for eight intervals, precharge, eight refreshes, mode load, refresh.
// - A write to any low three configuration bytes abandons activity and restarts initialization.
module srsc_ctrl
	import srsc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic [3:0]  regByteEn,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdData,
	input  wire logic        accPending,
	input  wire logic        accReadPending,
	input  wire logic        accBusy,
	input  wire logic        bankOpen,
	output logic             accGrant,
	output logic      [2:0]  memCmd,
	output logic             memA10,
	output logic             memCke,
	output logic             dataParkEnable,
	output logic             selfRefreshActive,
	output logic             initBusy
);
	srsc_state_type state_q;
	srsc_state_type state_d;
	srsc_cmd_type   memCmd_q;
	srsc_cmd_type   cmd_d;
	logic [3:0]     initCnt_q;
	logic [3:0]     initCnt_d;
	logic [7:0]     cfgByte_q [3];
	logic           srBit_q;
	logic [12:0]    rr_q;
	logic [12:0]    rr_d;
	logic           rrLoad_q;
	logic           mustHold_q;
	logic           mustHold_d;
	logic           accGrant_q;
	logic           accGrant_d;
	logic           initBusy_q;
	logic           initBusy_d;
	logic           srActive_q;
	logic           srActive_d;
	logic           memCke_q;
	logic           memA10_q;
	logic           park_q;
	logic [31:0]    regRdData_q;
	logic [31:0]    rdValue;
	logic [3:0]     backlog;
	logic           cfgWrite;
	logic           cfgLowWrite;
	logic           srWrite;
	logic           rrWrite;
	logic           lvlMay;
	logic           lvlRelease;
	logic           lvlNeed;
	logic           lvlMust;
	logic           refreshGo;
	logic           srEnterOk;
	logic           srWake;

	srsc_refresh_if rif ();

	srsc_refresh_counter u_counter (
		.mclk  (mclk),
		.reset (reset),
		.rif   (rif)
	);

	function automatic logic [7:0] pickByte(input logic en, input logic [7:0] fresh, input logic [7:0] old);
		pickByte = en ? fresh : old;
	endfunction : pickByte

	assign backlog = rif.backlog;

	// Register decode.
	assign cfgWrite    = regWrite && (regAddr == CFG_OFFSET);
	assign cfgLowWrite = cfgWrite && (regByteEn[2:0] != 3'h0);
	assign srWrite     = cfgWrite && regByteEn[SR_LANE];
	assign rrWrite     = regWrite && (regAddr == RFC_OFFSET) && (regByteEn[1:0] != 2'h0);

	assign rr_d[7:0]  = pickByte(regByteEn[0], regWrData[7:0], rr_q[7:0]);
	assign rr_d[12:8] = regByteEn[1] ? regWrData[12:8] : rr_q[12:8];

	assign rdValue = (regAddr == CFG_OFFSET) ? {srBit_q, 7'h00, cfgByte_q[2], cfgByte_q[1], cfgByte_q[0]} :
		(regAddr == RFC_OFFSET) ? {19'h00000, rr_q} :
		(regAddr == STAT_OFFSET) ? {24'h000000, memCke_q, mustHold_q, srActive_q, initBusy_q, backlog} :
		32'h00000000;

	// Urgency levels of the backlog.
	assign lvlMay     = (backlog != 4'h0) && (backlog < LVL_RELEASE);
	assign lvlRelease = (backlog >= LVL_RELEASE) && (backlog < LVL_NEED);
	assign lvlNeed    = (backlog >= LVL_NEED) && (backlog < LVL_MUST);
	assign lvlMust    = (backlog >= LVL_MUST);

	// Once in the top level, keep refreshing until the backlog is back under eight.
	assign mustHold_d = lvlMust ? 1'b1 : ((backlog < LVL_NEED) ? 1'b0 : mustHold_q);

	// No enable term exists here, so scheduling never stops while the block runs.
	assign refreshGo = (lvlMay && !accPending && !bankOpen && !accBusy)
		|| (lvlRelease && !accPending && !accBusy)
		|| (lvlNeed && !accBusy && !accReadPending)
		|| (mustHold_d && !accBusy)
		|| (srBit_q && !accPending && !accBusy && backlog != 4'h0);

	assign srEnterOk = srBit_q && !accPending && !accBusy && (backlog == 4'h0);
	assign srWake    = !srBit_q || accPending;

	always_comb
	begin
		state_d   = state_q;
		initCnt_d = initCnt_q;
		unique case (state_q)
			ST_INIT_ABORT:
				state_d = ST_INIT_NOP;
			ST_INIT_NOP:
			begin
				if (rif.expire)
				begin
					initCnt_d = initCnt_q + 4'h1;
					if (initCnt_q == INIT_INTERVALS - 4'h1)
						state_d = ST_INIT_PRE;
				end
			end
			ST_INIT_PRE:
			begin
				initCnt_d = 4'h0;
				state_d   = ST_INIT_REF;
			end
			ST_INIT_REF:
			begin
				initCnt_d = initCnt_q + 4'h1;
				if (initCnt_q == INIT_REFRESHES - 4'h1)
					state_d = ST_INIT_LMR;
			end
			ST_INIT_LMR:
				state_d = ST_REF_PRE;
			ST_IDLE:
			begin
				if (refreshGo)
					state_d = ST_REF_PRE;
				else if (srEnterOk)
					state_d = ST_SR_PRE;
			end
			ST_REF_PRE:
				state_d = ST_REF_CMD;
			ST_REF_CMD:
				state_d = ST_IDLE;
			ST_SR_PRE:
				state_d = ST_SR_ENTER;
			ST_SR_ENTER:
				state_d = ST_SR_ACTIVE;
			ST_SR_ACTIVE:
			begin
				if (srWake)
					state_d = ST_SR_EXIT;
			end
			ST_SR_EXIT:
				state_d = ST_REF_PRE;
			default:
				state_d = ST_INIT_NOP;
		endcase
		// Restart wins over everything, including a pending self-refresh.
		if (cfgLowWrite)
		begin
			state_d   = bankOpen ? ST_INIT_ABORT : ST_INIT_NOP;
			initCnt_d = 4'h0;
		end
	end

	assign cmd_d = (state_d == ST_INIT_ABORT || state_d == ST_INIT_PRE || state_d == ST_REF_PRE
		|| state_d == ST_SR_PRE) ? CMD_PRE_ALL :
		(state_d == ST_INIT_REF || state_d == ST_REF_CMD) ? CMD_REF :
		(state_d == ST_INIT_LMR) ? CMD_LMR :
		(state_d == ST_SR_ENTER) ? CMD_SELF_REFRESH_ENTRY_CMD : CMD_NOP;

	assign srActive_d = (state_d == ST_SR_ENTER) || (state_d == ST_SR_ACTIVE);
	assign accGrant_d = (state_d == ST_IDLE) && !mustHold_d && !initBusy_d;
	assign initBusy_d = cfgLowWrite ? 1'b1 : ((state_q == ST_REF_CMD && state_d == ST_IDLE) ? 1'b0 : initBusy_q);

	// The refresh counted back is the one issued in this cycle.
	assign rif.refDone = (state_q == ST_REF_CMD);
	assign rif.rrLoad  = rrLoad_q;
	assign rif.rrValue = rr_q;

	genvar lane;
	generate
		for (lane = 0; lane < 3; lane++)
		begin : g_cfg_lane
			always_ff @(posedge mclk or posedge reset)
			begin
				if (reset)
					cfgByte_q[lane] <= CFG_RESET;
				else if (cfgWrite && regByteEn[lane])
					cfgByte_q[lane] <= regWrData[lane*8 +: 8];
			end
		end
	endgenerate

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			srBit_q  <= 1'b0;
			rr_q     <= RR_RESET;
			rrLoad_q <= 1'b0;
		end
		else
		begin
			srBit_q  <= srWrite ? regWrData[SR_BIT_POS] : srBit_q;
			rr_q     <= rrWrite ? rr_d : rr_q;
			rrLoad_q <= rrWrite;
		end
	end

	// Registers stay reachable in every state, self-refresh included.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			regRdData_q <= 32'h00000000;
		else
			regRdData_q <= regRead ? rdValue : 32'h00000000;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state_q    <= ST_INIT_NOP;
			initCnt_q  <= 4'h0;
			mustHold_q <= 1'b0;
			initBusy_q <= 1'b1;
		end
		else
		begin
			state_q    <= state_d;
			initCnt_q  <= initCnt_d;
			mustHold_q <= mustHold_d;
			initBusy_q <= initBusy_d;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			memCmd_q   <= CMD_NOP;
			memA10_q   <= 1'b0;
			memCke_q   <= 1'b1;
			park_q     <= 1'b1;
			srActive_q <= 1'b0;
			accGrant_q <= 1'b0;
		end
		else
		begin
			memCmd_q   <= cmd_d;
			memA10_q   <= (cmd_d == CMD_PRE_ALL);
			memCke_q   <= !srActive_d;
			park_q     <= !srActive_d;
			srActive_q <= srActive_d;
			accGrant_q <= accGrant_d;
		end
	end

	assign regRdData         = regRdData_q;
	assign accGrant          = accGrant_q;
	assign memCmd            = memCmd_q;
	assign memA10            = memA10_q;
	assign memCke            = memCke_q;
	assign dataParkEnable    = park_q;
	assign selfRefreshActive = srActive_q;
	assign initBusy          = initBusy_q;

	property p_rr_reset;
		@(posedge mclk) disable iff (reset)
		$fell(reset) |-> rr_q == RR_RESET;
	endproperty
	a_rr_reset: assert property (p_rr_reset) else $error("refresh period not 190h after reset");

	property p_ref_cycle;
		@(posedge mclk) disable iff (reset)
		state_q == ST_REF_CMD |-> memCmd_q == CMD_REF && $past(memCmd_q) == CMD_PRE_ALL && $past(memA10_q);
	endproperty
	a_ref_cycle: assert property (p_ref_cycle) else $error("refresh not preceded by all-bank precharge");

	property p_must_block;
		@(posedge mclk) disable iff (reset)
		(backlog >= LVL_MUST) |=> !accGrant_q ##1 !accGrant_q;
	endproperty
	a_must_block: assert property (p_must_block) else $error("requests accepted at top urgency");

	property p_may_wait;
		@(posedge mclk) disable iff (reset)
		(state_q == ST_IDLE && lvlMay && bankOpen && !srBit_q && !cfgLowWrite) |=> state_q == ST_IDLE;
	endproperty
	a_may_wait: assert property (p_may_wait) else $error("low urgency refresh with a bank open");

	property p_release_go;
		@(posedge mclk) disable iff (reset)
		(state_q == ST_IDLE && lvlRelease && !accPending && !accBusy && !cfgLowWrite) |=> memCmd_q == CMD_PRE_ALL;
	endproperty
	a_release_go: assert property (p_release_go) else $error("refresh not started at release level");

	property p_self_refresh_entry_cmd_entry;
		@(posedge mclk) disable iff (reset)
		state_q == ST_SR_PRE |-> $past(backlog) == 4'h0 && !$past(accPending) && $past(srBit_q);
	endproperty
	a_self_refresh_entry_cmd_entry: assert property (p_self_refresh_entry_cmd_entry) else $error("self-refresh entered with work outstanding");

	property p_wake;
		@(posedge mclk) disable iff (reset)
		(state_q == ST_SR_ACTIVE && srWake && !cfgLowWrite) |=> state_q == ST_SR_EXIT && memCke_q;
	endproperty
	a_wake: assert property (p_wake) else $error("self-refresh not left on wake event");

	property p_exit_refresh;
		@(posedge mclk) disable iff (reset)
		(state_q == ST_SR_EXIT && !cfgLowWrite) |=> memCmd_q == CMD_PRE_ALL && memCke_q;
	endproperty
	a_exit_refresh: assert property (p_exit_refresh) else $error("no refresh cycle after self-refresh exit");

	property p_sr_park;
		@(posedge mclk) disable iff (reset)
		srActive_q |-> !dataParkEnable && !memCke_q;
	endproperty
	a_sr_park: assert property (p_sr_park) else $error("data bus parked during self-refresh");

	property p_restart;
		@(posedge mclk) disable iff (reset)
		cfgLowWrite |=> initBusy_q && (state_q == ST_INIT_NOP || state_q == ST_INIT_ABORT);
	endproperty
	a_restart: assert property (p_restart) else $error("configuration write did not restart init");

	property p_top_byte;
		@(posedge mclk) disable iff (reset)
		(cfgWrite && regByteEn == 4'h8 && !initBusy_q) |=> !initBusy_q && srBit_q == $past(regWrData[SR_BIT_POS]);
	endproperty
	a_top_byte: assert property (p_top_byte) else $error("top byte write restarted init");

	c_sr_enter: cover property (@(posedge mclk) disable iff (reset) state_q == ST_SR_ACTIVE);
	c_must: cover property (@(posedge mclk) disable iff (reset) backlog >= LVL_MUST);
	c_init_done: cover property (@(posedge mclk) disable iff (reset) $fell(initBusy_q));
	c_wake_access: cover property (@(posedge mclk) disable iff (reset) state_q == ST_SR_ACTIVE && accPending);
endmodule : srsc_ctrl

`default_nettype wire

// ---- srsc_sdram_model.sv ----
// Purpose: Far-side memory model that watches the command link and counts what arrives.
// Assumes: Commands change only at rising edges of mclk.
// Notes:   It never answers, so it only judges order and the precharge A10 bit; bad counts every out-of-order command.
`default_nettype none

module srsc_sdram_model
	import srsc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [2:0] memCmd,
	input  wire logic       memA10,
	input  wire logic       memCke
);
	timeunit 1ns;
	timeprecision 1ps;

	int         refs;
	int         lmrs;
	int         exits;
	int         bad;
	int         gap;
	int         cyc;
	int         lastPre;
	int         arm;
	logic [2:0] prevCmd;
	logic       prevCke;

	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			refs = 0;
			lmrs = 0;
			exits = 0;
			bad = 0;
			gap = 0;
			cyc = 0;
			lastPre = 0;
			arm = 0;
			prevCmd = CMD_NOP;
			prevCke = 1'b1;
		end
		else
		begin
			cyc++;
			if (memCmd === CMD_PRE_ALL)
			begin
				if (memA10 !== 1'b1) bad++;
				gap = cyc - lastPre;
				lastPre = cyc;
			end
			if (memCmd === CMD_REF)
			begin
				refs++;
				if (prevCmd !== CMD_PRE_ALL && prevCmd !== CMD_REF) bad++;
			end
			if (memCmd === CMD_LMR) lmrs++;
			if (memCmd === CMD_SELF_REFRESH_ENTRY_CMD && prevCmd !== CMD_PRE_ALL) bad++;
			// A device in self-refresh must see nothing but the entry command and no-ops.
			if (memCke === 1'b0 && memCmd !== CMD_NOP && memCmd !== CMD_SELF_REFRESH_ENTRY_CMD) bad++;
			if (memCke === 1'b1 && prevCke === 1'b0)
				arm = 1;
			else if (arm == 1 && memCmd !== CMD_NOP)
			begin
				if (memCmd !== CMD_PRE_ALL) bad++;
				arm = (memCmd === CMD_PRE_ALL) ? 2 : 0;
			end
			else if (arm == 2)
			begin
				if (memCmd === CMD_REF) exits++;
				else bad++;
				arm = 0;
			end
			prevCmd = memCmd;
			prevCke = memCke;
		end
	end
endmodule : srsc_sdram_model

`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the refresh and self-refresh controller.
// Assumes: Registers are reached over the one-cycle strobe port, data one cycle after a read.
// Notes:   Small refresh periods keep initialization and backlog build-up short.
`default_nettype none

module testbench
	import srsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic [3:0]  regByteEn = 4'h0;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [31:0] regRdData;
	// Busy with reads pending keeps every urgency level quiet until the bench says so.
	logic        accPending = 1'b1;
	logic        accReadPending = 1'b1;
	logic        accBusy = 1'b1;
	logic        bankOpen = 1'b1;
	logic        accGrant;
	logic [2:0]  memCmd;
	logic        memA10;
	logic        memCke;
	logic        dataParkEnable;
	logic        selfRefreshActive;
	logic        initBusy;
	logic [31:0] rd;
	int          errors = 0;
	int          tests_run = 0;
	int          r0;
	int          x0;

	always #4 mclk = ~mclk;

	srsc_ctrl i_dut (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
		.regByteEn(regByteEn), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.accPending(accPending), .accReadPending(accReadPending), .accBusy(accBusy),
		.bankOpen(bankOpen), .accGrant(accGrant), .memCmd(memCmd), .memA10(memA10),
		.memCke(memCke), .dataParkEnable(dataParkEnable),
		.selfRefreshActive(selfRefreshActive), .initBusy(initBusy));

	srsc_sdram_model i_mem (.mclk(mclk), .reset(reset), .memCmd(memCmd), .memA10(memA10),
		.memCke(memCke));

	task automatic test_done;
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic ticks(input int n);
		repeat (n) @(posedge mclk);
	endtask : ticks

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge mclk);
		regWrite  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		regByteEn <= be;
		@(posedge mclk);
		regWrite  <= 1'b0;
	endtask : wr

	task automatic rdReg(input logic [3:0] a);
		@(posedge mclk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		rd = regRdData;
	endtask : rdReg

	task automatic waitOn(input int sel, input logic v, input int lim);
		logic s;
		for (int n = 0; n < lim; n++)
		begin
			@(posedge mclk);
			#1;
			case (sel)
				0:       s = initBusy;
				1:       s = selfRefreshActive;
				2:       s = accGrant;
				default: s = memCke;
			endcase
			if (s === v) return;
		end
		errors++;
		test_done();
	endtask : waitOn

	task automatic t_reset;
		rdReg(RFC_OFFSET);
		chk(rd, {19'h0, RR_RESET});
		rdReg(STAT_OFFSET);
		chk(rd[7:4], 4'h9);
		rdReg(4'hC);
		chk(rd, 32'h0);
		waitOn(0, 1'b0, 4000);
	endtask : t_reset

	task automatic t_init;
		wr(RFC_OFFSET, 32'h4, 4'h3);
		rdReg(RFC_OFFSET);
		chk(rd, 32'h4);
		for (int lane = 0; lane < 3; lane++)
		begin
			r0 = i_mem.refs;
			x0 = i_mem.lmrs;
			wr(CFG_OFFSET, 32'h00010203, 4'h1 << lane);
			waitOn(0, 1'b1, 5);
			waitOn(0, 1'b0, 200);
			chk(i_mem.refs - r0, 9);
			chk(i_mem.lmrs - x0, 1);
		end
	endtask : t_init

	task automatic t_levels;
		wr(RFC_OFFSET, 32'hFF, 4'h3);
		r0 = i_mem.refs;
		ticks(4116);
		rdReg(STAT_OFFSET);
		chk(rd[6:0], 7'h4F);
		chk(accGrant, 1'b0);
		chk(i_mem.refs - r0, 0);
		@(posedge mclk);
		accBusy <= 1'b0;
		waitOn(2, 1'b1, 100);
		rdReg(STAT_OFFSET);
		chk(rd[3:0], 4'h7);
		chk(i_mem.refs - r0, 8);
		// The next expiry lifts the backlog to eight while reads still wait.
		ticks(250);
		rdReg(STAT_OFFSET);
		chk(rd[3:0], 4'h8);
		@(posedge mclk);
		accReadPending <= 1'b0;
		ticks(6);
		rdReg(STAT_OFFSET);
		chk(rd[3:0], 4'h7);
		@(posedge mclk);
		accPending <= 1'b0;
		ticks(14);
		rdReg(STAT_OFFSET);
		chk(rd[3:0], 4'h3);
		@(posedge mclk);
		bankOpen <= 1'b0;
		ticks(12);
		rdReg(STAT_OFFSET);
		chk(rd[3:0], 4'h0);
	endtask : t_levels

	task automatic t_period;
		// A three-cycle period lines every expiry up with the end of a refresh cycle.
		wr(RFC_OFFSET, 32'h2, 4'h3);
		ticks(20);
		rdReg(STAT_OFFSET);
		chk(rd[3:0], 4'h1);
		wr(RFC_OFFSET, 32'h20, 4'h3);
		ticks(110);
		chk(i_mem.gap, 33);
	endtask : t_period

	task automatic t_selfref;
		x0 = i_mem.exits;
		wr(CFG_OFFSET, 32'h80000000, 4'h8);
		waitOn(1, 1'b1, 60);
		chk(initBusy, 1'b0);
		chk(memCke, 1'b0);
		chk(dataParkEnable, 1'b0);
		rdReg(STAT_OFFSET);
		chk(rd[7:4], 4'h2);
		wr(CFG_OFFSET, 32'h0, 4'h8);
		waitOn(3, 1'b1, 20);
		ticks(4);
		chk(i_mem.exits - x0, 1);
		wr(CFG_OFFSET, 32'h80000000, 4'h8);
		waitOn(1, 1'b1, 60);
		@(posedge mclk);
		accPending <= 1'b1;
		waitOn(3, 1'b1, 20);
		ticks(4);
		chk(i_mem.exits - x0, 2);
		chk(selfRefreshActive, 1'b0);
		wr(CFG_OFFSET, 32'h0, 4'h8);
		accPending <= 1'b0;
		wr(RFC_OFFSET, 32'h4, 4'h3);
		wr(CFG_OFFSET, 32'h00010203, 4'h7);
		waitOn(0, 1'b1, 5);
		waitOn(0, 1'b0, 200);
		rdReg(CFG_OFFSET);
		chk(rd, 32'h00010203);
	endtask : t_selfref

	initial
	begin
		ticks(16);
		reset <= 1'b0;
		t_reset();
		t_init();
		t_levels();
		t_period();
		t_selfref();
		ticks(10);
		chk(i_mem.bad, 0);
		test_done();
	end
endmodule : testbench

`default_nettype wire
